//--- mtc_defines.svh
// Offsets, field positions, reset values and timing counts
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH
`define MTC_OFF_SOURCE   8'h00
`define MTC_OFF_CONFIG   8'h04
`define MTC_OFF_COMMAND  8'h08
`define MTC_OFF_ENV      8'h0C
`define MTC_OFF_STATUS   8'h10
`define MTC_OFF_ERROR    8'h14
`define MTC_OFF_DELAY    8'h18
`define MTC_CMD_INIT     0
`define MTC_CMD_IMM      1
`define MTC_CMD_BUSTRG   2
`define MTC_CMD_MEASCONF 3
`define MTC_CMD_LOCAL    4
`define MTC_CMD_ABORT    5
`define MTC_ST_DLYQ      0
`define MTC_ST_WAIT      1
`define MTC_ST_SETTLE    2
`define MTC_ST_MEAS      3
`define MTC_ST_ERR       4
`define MTC_ST_LOOPS     8
`define MTC_ERR_CONFLICT 16'hFF23
`define MTC_RST_COUNT    6'h01
`define MTC_DLYQ_ON      1'h1
`define MTC_DLYQ_OFF     1'h0
`define MTC_SETTLE_NS    1000
`define MTC_CLK_NS       100
`define MTC_SETTLE_CYC   ((`MTC_SETTLE_NS + `MTC_CLK_NS - 1) / `MTC_CLK_NS)
`endif

//--- mtc_pkg.sv
// Types shared by the trigger control block
package mtc_pkg;
  typedef enum logic [2:0] {
    MTC_SRC_IMM  = 3'h0,
    MTC_SRC_BUS  = 3'h1,
    MTC_SRC_HOLD = 3'h2,
    MTC_SRC_EXT  = 3'h3,
    MTC_SRC_INTA = 3'h4,
    MTC_SRC_INTB = 3'h5
  } mtc_src_t;
  typedef enum logic [1:0] {
    MTC_DLY_OFF  = 2'h0,
    MTC_DLY_ON   = 2'h1,
    MTC_DLY_ONCE = 2'h2
  } mtc_dly_t;
  typedef enum logic [1:0] {
    MTC_RATE_NORMAL = 2'h0,
    MTC_RATE_DOUBLE = 2'h1,
    MTC_RATE_FAST   = 2'h2
  } mtc_rate_t;
  // CONFIG register layout, high bits first
  typedef struct packed {
    logic [5:0] count;
    mtc_rate_t  rate;
    logic       cont;
    mtc_dly_t   dly;
  } mtc_cfg_t;
  // ENV register layout: facts about sensor and the other channel
  typedef struct packed {
    logic other_slaved;
    logic adj_peak;
    logic avg_only;
    logic det_avg;
    logic speed200;
  } mtc_env_t;
endpackage : mtc_pkg

//--- mtc_trigger_ctrl.sv
// Trigger control for one measurement channel, AHB-Lite register slave
`timescale 1ns/1ps
`include "mtc_defines.svh"
module mtc_trigger_ctrl #(
  parameter int ERR_DEPTH  = 4,
  parameter int SETTLE_CYC = `MTC_SETTLE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_trig_in,
  input  wire logic        int_trig_a,
  input  wire logic        int_trig_b,
  input  wire logic        meas_done,
  output logic             meas_start,
  output logic             waiting_trig
);

  typedef enum logic [2:0] {
    MTC_IDLE, MTC_WAIT, MTC_DLY, MTC_SETTLE, MTC_MEAS
  } mtc_state_t;

  localparam int EW = $clog2(ERR_DEPTH);

  mtc_state_t        state;
  mtc_pkg::mtc_src_t src;
  mtc_pkg::mtc_cfg_t cfg;
  mtc_pkg::mtc_env_t env;
  logic [15:0]       trig_delay;
  logic [15:0]       cnt;
  logic [5:0]        loops;
  logic              wr_pend;
  logic              rd_pend;
  logic [7:0]        acc_addr;
  logic              ext_s1;
  logic              ext_s2;
  logic              ext_s3;
  logic              int_a_q;
  logic              int_b_q;
  logic [15:0]       err_q [ERR_DEPTH];
  logic [EW-1:0]     err_wp;
  logic [EW-1:0]     err_rp;
  logic [EW:0]       err_n;

  // True when the source cannot be taken with the present environment
  function automatic logic src_bad(input mtc_pkg::mtc_src_t s,
                                   input mtc_pkg::mtc_env_t e);
    logic intl;
    logic slv;
    intl = (s == mtc_pkg::MTC_SRC_INTA) || (s == mtc_pkg::MTC_SRC_INTB);
    slv  = (s == mtc_pkg::MTC_SRC_IMM) || (s == mtc_pkg::MTC_SRC_BUS) ||
           (s == mtc_pkg::MTC_SRC_HOLD);
    src_bad = (slv && e.other_slaved) ||
              ((intl || s == mtc_pkg::MTC_SRC_EXT) && e.speed200) ||
              (intl && e.det_avg) ||
              (intl && e.avg_only) ||
              (s == mtc_pkg::MTC_SRC_EXT && e.avg_only &&
               e.adj_peak);
  endfunction : src_bad

  // True when a count above one does not fit rate and source
  function automatic logic count_bad(input logic [5:0]         c,
                                     input mtc_pkg::mtc_rate_t r,
                                     input mtc_pkg::mtc_src_t  s);
    count_bad = (c > 6'h01) &&
                ((r != mtc_pkg::MTC_RATE_FAST) ||
                 (s == mtc_pkg::MTC_SRC_EXT) ||
                 (s == mtc_pkg::MTC_SRC_INTA) ||
                 (s == mtc_pkg::MTC_SRC_INTB));
  endfunction : count_bad

  // Write data phase decode
  logic              wr_src;
  logic              wr_cfg;
  logic              wr_cmd;
  mtc_pkg::mtc_src_t new_src;
  mtc_pkg::mtc_cfg_t new_cfg;
  logic              src_conf;
  logic              cfg_conf;
  logic              conflict;
  logic              cmd_init;
  logic              cmd_imm;
  logic              cmd_bus;
  logic              cmd_force;
  logic              cmd_abort;

  assign wr_src    = wr_pend && (acc_addr == `MTC_OFF_SOURCE);
  assign wr_cfg    = wr_pend && (acc_addr == `MTC_OFF_CONFIG);
  assign wr_cmd    = wr_pend && (acc_addr == `MTC_OFF_COMMAND);
  assign new_src   = mtc_pkg::mtc_src_t'(hwdata[2:0]);
  assign new_cfg   = mtc_pkg::mtc_cfg_t'(hwdata[10:0]);
  assign src_conf  = wr_src && (hwdata[2:0] > 3'h5 ||
                     src_bad(new_src, env) ||
                     count_bad(cfg.count, cfg.rate, new_src));
  assign cfg_conf  = wr_cfg && (count_bad(new_cfg.count, new_cfg.rate, src) ||
                     new_cfg.count == 6'h00 || hwdata[4:3] == 2'h3 ||
                     hwdata[1:0] == 2'h3);
  assign conflict  = src_conf || cfg_conf;
  assign cmd_init  = wr_cmd && hwdata[`MTC_CMD_INIT];
  assign cmd_imm   = wr_cmd && hwdata[`MTC_CMD_IMM];
  assign cmd_bus   = wr_cmd && hwdata[`MTC_CMD_BUSTRG];
  assign cmd_force = wr_cmd && (hwdata[`MTC_CMD_MEASCONF] ||
                                hwdata[`MTC_CMD_LOCAL]);
  assign cmd_abort = wr_cmd && hwdata[`MTC_CMD_ABORT];

  // Trigger event for the selected source
  logic trig_hit;
  logic settle_on;
  logic after_dly;
  logic settle_take;

  always_comb begin
    unique case (src)
      mtc_pkg::MTC_SRC_IMM:  trig_hit = 1'b1;
      mtc_pkg::MTC_SRC_BUS:  trig_hit = cmd_bus;
      mtc_pkg::MTC_SRC_HOLD: trig_hit = 1'b0;
      mtc_pkg::MTC_SRC_EXT:  trig_hit = ext_s2 && !ext_s3;
      mtc_pkg::MTC_SRC_INTA: trig_hit = int_trig_a && !int_a_q;
      mtc_pkg::MTC_SRC_INTB: trig_hit = int_trig_b && !int_b_q;
      default:               trig_hit = 1'b0;
    endcase
  end

  assign settle_on   = cfg.dly != mtc_pkg::MTC_DLY_OFF;
  assign after_dly   = (state == MTC_WAIT && !cmd_imm && trig_hit &&
                        trig_delay == 16'h0000) ||
                       (state == MTC_DLY && cnt == 16'h0001);
  assign settle_take = after_dly && settle_on;

  // AHB-Lite slave: writes take no wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      acc_addr  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      if (rd_pend) begin
        hreadyout <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
        acc_addr  <= haddr[7:0];
        wr_pend   <= hwrite;
        rd_pend   <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // Read data, loaded in the wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= 32'h0000_0000;
      unique case (acc_addr)
        `MTC_OFF_SOURCE: hrdata[2:0]  <= src;
        `MTC_OFF_CONFIG: hrdata[10:0] <= cfg;
        `MTC_OFF_ENV:    hrdata[4:0]  <= env;
        `MTC_OFF_DELAY:  hrdata[15:0] <= trig_delay;
        `MTC_OFF_STATUS: begin
          hrdata[`MTC_ST_DLYQ]   <= settle_on ? `MTC_DLYQ_ON
                                              : `MTC_DLYQ_OFF;
          hrdata[`MTC_ST_WAIT]   <= state == MTC_WAIT;
          hrdata[`MTC_ST_SETTLE] <= state == MTC_SETTLE;
          hrdata[`MTC_ST_MEAS]   <= state == MTC_MEAS;
          hrdata[`MTC_ST_ERR]    <= err_n != '0;
          hrdata[`MTC_ST_LOOPS +: 6] <= loops;
        end
        `MTC_OFF_ERROR: begin
          if (err_n != '0) begin
            hrdata <= {{16{err_q[err_rp][15]}}, err_q[err_rp]};
          end
        end
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Source selection; a write never arms the channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src <= mtc_pkg::MTC_SRC_IMM;
    end else if (cmd_force) begin
      src <= mtc_pkg::MTC_SRC_IMM;
    end else if (wr_src && !src_conf) begin
      src <= new_src;
    end
  end

  // Configuration; settling once falls back to off when used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.dly   <= mtc_pkg::MTC_DLY_ON;
      cfg.cont  <= 1'b0;
      cfg.rate  <= mtc_pkg::MTC_RATE_NORMAL;
      cfg.count <= `MTC_RST_COUNT;
    end else if (wr_cfg && !cfg_conf) begin
      cfg <= new_cfg;
    end else if (settle_take && cfg.dly == mtc_pkg::MTC_DLY_ONCE) begin
      cfg.dly <= mtc_pkg::MTC_DLY_OFF;
    end
  end

  // Environment and programmed trigger delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      env        <= '0;
      trig_delay <= 16'h0000;
    end else if (wr_pend && acc_addr == `MTC_OFF_ENV) begin
      env <= mtc_pkg::mtc_env_t'(hwdata[4:0]);
    end else if (wr_pend && acc_addr == `MTC_OFF_DELAY) begin
      trig_delay <= hwdata[15:0];
    end
  end

  // Error queue; when full the newest error is dropped
  logic err_pop;
  logic err_push;
  assign err_pop  = rd_pend && acc_addr == `MTC_OFF_ERROR && err_n != '0;
  assign err_push = conflict && (err_n < (EW+1)'(ERR_DEPTH) || err_pop);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_wp <= '0;
      err_rp <= '0;
      err_n  <= '0;
    end else begin
      if (err_push) begin
        err_wp <= (err_wp == EW'(ERR_DEPTH - 1)) ? '0 : err_wp + 1'b1;
      end
      if (err_pop) begin
        err_rp <= (err_rp == EW'(ERR_DEPTH - 1)) ? '0 : err_rp + 1'b1;
      end
      err_n <= err_n + (EW+1)'(err_push) - (EW+1)'(err_pop);
    end
  end

  // Storage has no reset; only entries below the count are ever read
  always_ff @(posedge hclk) begin
    if (err_push) begin
      err_q[err_wp] <= `MTC_ERR_CONFLICT;
    end
  end

  // Trigger input edges; the rear input is synchronised first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      int_a_q <= 1'b0;
      int_b_q <= 1'b0;
    end else begin
      ext_s1  <= ext_trig_in;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      int_a_q <= int_trig_a;
      int_b_q <= int_trig_b;
    end
  end

  // Trigger sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= MTC_IDLE;
      cnt          <= 16'h0000;
      loops        <= 6'h00;
      meas_start   <= 1'b0;
      waiting_trig <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      if (cmd_abort) begin
        state        <= MTC_IDLE;
        waiting_trig <= 1'b0;
      end else begin
        unique case (state)
          MTC_IDLE: begin
            if (cmd_init || cfg.cont) begin
              state        <= MTC_WAIT;
              loops        <= cfg.count;
              waiting_trig <= 1'b1;
            end
          end
          MTC_WAIT: begin
            if (cmd_imm) begin
              // Skips both trigger delay and settling
              state        <= MTC_MEAS;
              meas_start   <= 1'b1;
              waiting_trig <= 1'b0;
            end else if (trig_hit) begin
              waiting_trig <= 1'b0;
              if (trig_delay != 16'h0000) begin
                state <= MTC_DLY;
                cnt   <= trig_delay;
              end else if (settle_take) begin
                state <= MTC_SETTLE;
                cnt   <= 16'(SETTLE_CYC);
              end else begin
                state      <= MTC_MEAS;
                meas_start <= 1'b1;
              end
            end
          end
          MTC_DLY: begin
            cnt <= cnt - 16'h0001;
            if (settle_take) begin
              state <= MTC_SETTLE;
              cnt   <= 16'(SETTLE_CYC);
            end else if (after_dly) begin
              state      <= MTC_MEAS;
              meas_start <= 1'b1;
            end
          end
          MTC_SETTLE: begin
            cnt <= cnt - 16'h0001;
            if (cnt <= 16'h0001) begin
              state      <= MTC_MEAS;
              meas_start <= 1'b1;
            end
          end
          MTC_MEAS: begin
            if (meas_done) begin
              if (loops > 6'h01) begin
                loops        <= loops - 6'h01;
                state        <= MTC_WAIT;
                waiting_trig <= 1'b1;
              end else if (cfg.cont) begin
                loops        <= cfg.count;
                state        <= MTC_WAIT;
                waiting_trig <= 1'b1;
              end else begin
                loops <= 6'h00;
                state <= MTC_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : mtc_trigger_ctrl

//--- mtc_trigger_ctrl_asserts.sv
// Port-level checks for the trigger control block
`timescale 1ns/1ps
`include "mtc_defines.svh"
module mtc_trigger_ctrl_asserts #(
  parameter int ERR_DEPTH  = 4,
  parameter int SETTLE_CYC = 10
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_trig_in,
  input wire logic        int_trig_a,
  input wire logic        int_trig_b,
  input wire logic        meas_done,
  input wire logic        meas_start,
  input wire logic        waiting_trig
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic       pend;
  logic       pwr;
  logic [7:0] poff;
  logic       last;
  assign take = hsel & htrans[1] & hready;
  assign last = pend & hreadyout;
  // Data-phase tracker; only single transfers are expected here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pwr  <= 1'b0;
      poff <= 8'h00;
    end else if (take) begin
      pend <= 1'b1;
      pwr  <= hwrite;
      poff <= haddr[7:0];
    end else if (hreadyout) begin
      pend <= 1'b0;
    end
  end
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_imm_cmd;
    last && pwr && poff == `MTC_OFF_COMMAND &&
      hwdata[`MTC_CMD_IMM] && waiting_trig;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  a_start_exit: assert property (meas_start |-> !waiting_trig)
    else $error("still waiting at start");
  a_imm_ends_wait: assert property (
    s_imm_cmd |-> ##[1:2] meas_start)
    else $error("immediate trigger did not start");
  a_rdata_stable: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  a_err_code: assert property (last && !pwr && poff == `MTC_OFF_ERROR |->
    hrdata == {16'hFFFF, `MTC_ERR_CONFLICT} || hrdata == 32'h0)
    else $error("error code not recognised");
endmodule : mtc_trigger_ctrl_asserts
bind mtc_trigger_ctrl mtc_trigger_ctrl_asserts #(
  .ERR_DEPTH(ERR_DEPTH), .SETTLE_CYC(SETTLE_CYC)
) mtc_trigger_ctrl_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_trig_in(ext_trig_in), .int_trig_a(int_trig_a),
  .int_trig_b(int_trig_b), .meas_done(meas_done),
  .meas_start(meas_start), .waiting_trig(waiting_trig)
);

//--- mtc_meas_engine.sv
// Measurement engine model: one done pulse a fixed time after each start
`timescale 1ns/1ps
module mtc_meas_engine #(
  parameter int LAT = 3
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic meas_start,
  output logic      meas_done
);
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt       <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (cnt == 1);
      if (meas_start) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : mtc_meas_engine

//--- testbench.sv
// Self-checking bench for the trigger control block
`timescale 1ns/1ps
`include "mtc_defines.svh"
module testbench;
  localparam int SETTLE = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  trg = 3'h0;
  logic        meas_done;
  logic        meas_start;
  logic        waiting_trig;
  int          fails = 0;
  int          checked = 0;
  int          t_on;
  int          t_off;
  int          n;
  logic [31:0] q;
  logic [31:0] prev;
  logic [31:0] c_env [7] = '{32'h01, 32'h02, 32'h04, 32'h0C, 32'h10, 0, 0};
  logic [7:0]  c_off [7] = '{0, 0, 0, 0, 0, 8'h04, 8'h04};
  logic [31:0] c_dat [7] = '{32'h3, 32'h4, 32'h5, 32'h3, 32'h1, 32'h41,
                             32'h49};
  always #50 hclk = ~hclk;
  mtc_trigger_ctrl #(.ERR_DEPTH(4), .SETTLE_CYC(SETTLE)) mtc_trigger_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_trig_in(trg[0]), .int_trig_a(trg[1]),
    .int_trig_b(trg[2]), .meas_done(meas_done), .meas_start(meas_start),
    .waiting_trig(waiting_trig));
  mtc_meas_engine #(.LAT(3)) mtc_meas_engine_i (
    .hclk(hclk), .hresetn(hresetn), .meas_start(meas_start),
    .meas_done(meas_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  // Counts falling edges until a start pulse, bounded
  task automatic waitst(output int c);
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (meas_start !== 1'b1 && c < 300);
  endtask : waitst
  task automatic starts(input int k, output int s);
    s = 0;
    repeat (k) begin
      @(negedge hclk);
      if (meas_start === 1'b1) s++;
    end
  endtask : starts
  task automatic pulse(input int i);
    @(posedge hclk);
    trg[i] <= 1'b1;
    repeat (2) @(posedge hclk);
    trg[i] <= 1'b0;
  endtask : pulse
  // Engine answers in a few cycles; this lets the channel go idle
  task automatic rest;
    repeat (8) @(posedge hclk);
  endtask : rest
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`MTC_OFF_SOURCE, q); chk(q, 32'h0);
    rd(`MTC_OFF_CONFIG, q); chk(q, 32'h21);
    rd(`MTC_OFF_STATUS, q); chk(q & 32'hF, 32'h1);
    rd(8'h40, q); chk(q, 32'h0);
    wr(`MTC_OFF_COMMAND, 32'h1); waitst(t_on); rest();
    wr(`MTC_OFF_CONFIG, 32'h20); wr(`MTC_OFF_COMMAND, 32'h1);
    waitst(t_off); rest();
    chk(32'(t_on - t_off), SETTLE);
    rd(`MTC_OFF_STATUS, q); chk(q & 32'h1, 32'h0);
    wr(`MTC_OFF_CONFIG, 32'h22);
    wr(`MTC_OFF_COMMAND, 32'h1); waitst(n); chk(32'(n), 32'(t_on));
    rest();
    wr(`MTC_OFF_COMMAND, 32'h1); waitst(n); chk(32'(n), 32'(t_off));
    rest();
    rd(`MTC_OFF_CONFIG, q); chk(q, 32'h20);
    wr(`MTC_OFF_CONFIG, 32'h21); wr(`MTC_OFF_SOURCE, 32'h1);
    starts(10, n); chk({31'h0, waiting_trig}, 32'h0);
    wr(`MTC_OFF_COMMAND, 32'h1); starts(20, n); chk(32'(n), 32'h0);
    chk({31'h0, waiting_trig}, 32'h1);
    wr(`MTC_OFF_COMMAND, 32'h4); waitst(n); chk({31'h0, meas_start}, 1);
    rest();
    wr(`MTC_OFF_SOURCE, 32'h2); wr(`MTC_OFF_COMMAND, 32'h1);
    wr(`MTC_OFF_COMMAND, 32'h4); starts(20, n); chk(32'(n), 32'h0);
    wr(`MTC_OFF_COMMAND, 32'h2); waitst(n); chk(32'(n < SETTLE), 1);
    starts(20, n); chk(32'(n), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`MTC_OFF_SOURCE, 32'(3 + i)); wr(`MTC_OFF_COMMAND, 32'h1);
      pulse((i + 1) % 3); starts(10, n); chk(32'(n), 32'h0);
      pulse(i); waitst(n); chk({31'h0, meas_start}, 1);
      rest();
    end
    for (int k = 3; k < 5; k++) begin
      wr(`MTC_OFF_SOURCE, 32'h3); wr(`MTC_OFF_COMMAND, 32'h1 << k);
      rd(`MTC_OFF_SOURCE, q); chk(q, 32'h0);
    end
    for (int k = 0; k < 7; k++) begin
      wr(`MTC_OFF_ENV, c_env[k]); rd(c_off[k], prev); wr(c_off[k], c_dat[k]);
      rd(c_off[k], q); chk(q, prev);
      rd(`MTC_OFF_ERROR, q); chk(q, {16'hFFFF, `MTC_ERR_CONFLICT});
    end
    wr(`MTC_OFF_ENV, 32'h0); rd(`MTC_OFF_ERROR, q); chk(q, 32'h0);
    wr(`MTC_OFF_CONFIG, 32'h70); rd(`MTC_OFF_CONFIG, q); chk(q, 32'h70);
    wr(`MTC_OFF_SOURCE, 32'h3); rd(`MTC_OFF_SOURCE, q); chk(q, 32'h0);
    rd(`MTC_OFF_ERROR, q); chk(q, {16'hFFFF, `MTC_ERR_CONFLICT});
    wr(`MTC_OFF_SOURCE, 32'h1); wr(`MTC_OFF_COMMAND, 32'h1);
    repeat (3) begin
      n = 0;
      while (waiting_trig !== 1'b1 && n < 50) begin
        @(negedge hclk);
        n++;
      end
      wr(`MTC_OFF_COMMAND, 32'h4); waitst(n); chk({31'h0, meas_start}, 1);
    end
    rest(); chk({31'h0, waiting_trig}, 32'h0);
    wr(`MTC_OFF_CONFIG, 32'h24); wr(`MTC_OFF_SOURCE, 32'h0);
    starts(60, n); chk(32'(n >= 3), 32'h1);
    wr(`MTC_OFF_CONFIG, 32'h20); wr(`MTC_OFF_COMMAND, 32'h20); rest();
    starts(20, n); chk(32'(n), 32'h0);
    wr(`MTC_OFF_COMMAND, 32'h1); starts(30, n); chk(32'(n), 32'h1);
    wr(`MTC_OFF_DELAY, 32'h5); rd(`MTC_OFF_DELAY, q); chk(q, 32'h5);
    wr(`MTC_OFF_COMMAND, 32'h1);
    waitst(n); chk(32'(n), 32'(t_off + 5));
    rest();
    wr(`MTC_OFF_CONFIG, 32'h21); wr(`MTC_OFF_COMMAND, 32'h1);
    waitst(n); chk(32'(n), 32'(t_on + 5));
    rest();
    wr(`MTC_OFF_SOURCE, 32'h2); wr(`MTC_OFF_COMMAND, 32'h1);
    rd(`MTC_OFF_STATUS, q); chk(q, 32'h0000_0103);
    wr(`MTC_OFF_COMMAND, 32'h2);
    waitst(n); chk(32'(n), 32'h1);
    rest();
    tally_and_finish();
  end
endmodule : testbench
